// file: ddps_map.vh
// ddps_map.vh: register offsets, field positions and reset values
// for the dual data pointer select block; definitions only.
`ifndef DDPS_MAP_VH
`define DDPS_MAP_VH

// ****************************************
// register address
// ****************************************
`define DDPS_AUX_ADDR        8'hA2

// ****************************************
// field positions of the aux control register
// ****************************************
`define DDPS_SEL_BIT         0
`define DDPS_ZERO_BIT        2
`define DDPS_FLAG_BIT        3
`define DDPS_BOOT_BIT        5

// ****************************************
// reset values and boot window
// ****************************************
`define DDPS_FLAG_RST        1'b0
`define DDPS_PTR_RST         16'h0000
`define DDPS_BOOT_LO         16'hF800
`define DDPS_BOOT_HI         16'hFFFF

`endif

// file: ddps_ptr_reg.v
// ddps_ptr_reg.v: one 16-bit data pointer with load and increment.
// assumes the caller gates load and increment with the pointer select.
`timescale 1ns/1ps
`include "ddps_map.vh"

module ddps_ptr_reg #(
   parameter WIDTH = 16
) (
   input  wire             clk_in,
   input  wire             srst_in,
   input  wire             load_in,
   input  wire             inc_in,
   input  wire [WIDTH-1:0] data_in,
   output wire [WIDTH-1:0] value_out
);

   reg [WIDTH-1:0] ptr_q;

   // ****************************************
   // pointer storage
   // ****************************************
   // load wins over increment; idle keeps the value
   always @(posedge clk_in) begin
      if (srst_in) begin
         ptr_q <= {WIDTH{1'b0}};                     // pointers clear on reset
      end else if (load_in) begin
         ptr_q <= data_in;
      end else if (inc_in) begin
         ptr_q <= ptr_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign value_out = ptr_q;

endmodule

// file: ddps_sva.sv
// ddps_sva.sv: port-level checker for the dual data pointer block.
// assumes it is bound into ddps_top and sees only its ports.
`timescale 1ns/1ps
module ddps_sva #(
   parameter PTR_W = 16
) (
   input logic             clk_in,
   input logic             srst_in,
   input logic [7:0]       sfr_addr_in,
   input logic             sfr_wr_in,
   input logic             sfr_inc_in,
   input logic             sfr_rd_in,
   input logic [7:0]       sfr_wdata_in,
   input logic [7:0]       sfr_rdata_out,
   input logic             sfr_hit_out,
   input logic             ptr_load_in,
   input logic [PTR_W-1:0] ptr_data_in,
   input logic             xdata_req_in,
   input logic             xdata_valid_out,
   input logic [PTR_W-1:0] data_pointer_out,
   input logic [15:0]      code_addr_in,
   input logic             boot_select_out,
   input logic             pointer_select_out
);
   // ****************************************
   // register and pointer relations
   // ****************************************
   wire hit = sfr_addr_in == 8'hA2;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   a_hit_addr: assert property (sfr_hit_out == $past(hit && (sfr_wr_in || sfr_inc_in || sfr_rd_in)))
      else $error("hit does not follow strobe at aux address");
   a_rdata_idle: assert property (!$past(sfr_rd_in && hit) |-> sfr_rdata_out == 8'h00)
      else $error("read data outside read slot");
   a_rsvd_zero: assert property ((sfr_rdata_out & 8'hD6) == 8'h00)
      else $error("zero or reserved bit read as one");
   a_inc_toggle: assert property (sfr_inc_in && hit ##1 1 |=> pointer_select_out != $past(pointer_select_out))
      else $error("increment did not toggle select");
   a_wr_select: assert property (sfr_wr_in && !sfr_inc_in && hit |=> ##1 pointer_select_out == $past(sfr_wdata_in[0], 2))
      else $error("select does not follow written bit");
   a_xdata_valid: assert property (xdata_valid_out == $past(xdata_req_in))
      else $error("external access valid mismatch");
   a_boot_window: assert property (boot_select_out |-> $past(code_addr_in[15:11]) == 5'h1F)
      else $error("boot select outside boot window");
   a_ptr_load: assert property (ptr_load_in && !sfr_inc_in && !sfr_wr_in |=> ##1 data_pointer_out == $past(ptr_data_in, 2))
      else $error("loaded pointer value not shown");
endmodule
bind ddps_top ddps_sva #(.PTR_W(PTR_W)) u_sva (.*);

// file: ddps_top.v
// ddps_top.v: dual data pointer bank with its aux control register.
// assumes a core on clk_in issuing one-cycle strobes for special
// register access, pointer load/increment and external data access.
//
// How it works
// (R1) two independent 16-bit pointers address external data
// (R2) select bit zero picks pointer zero, one picks one
// (R3) bit two reads zero, ignores writes, blocks carry
// (R4) increment of the register toggles pointer select
// (R5) bit three is a plain software flag
// (R6) boot enable maps boot memory at F800h-FFFFh
// (R7) reserved bits read zero; software writes zeros
// (R8) reset clears select, loads boot enable from strap
// (R9) register sits at address A2h, byte access
// (R10) pointer operations touch only the selected pointer
`timescale 1ns/1ps
`include "ddps_map.vh"

module ddps_top #(
   parameter PTR_W = 16
) (
   input  wire             clk_in,
   input  wire             srst_in,
   input  wire [7:0]       sfr_addr_in,
   input  wire             sfr_wr_in,
   input  wire             sfr_inc_in,
   input  wire             sfr_rd_in,
   input  wire [7:0]       sfr_wdata_in,
   output reg  [7:0]       sfr_rdata_out,
   output reg              sfr_hit_out,
   input  wire             ptr_load_in,
   input  wire             ptr_inc_in,
   input  wire [PTR_W-1:0] ptr_data_in,
   input  wire             xdata_req_in,
   output reg  [PTR_W-1:0] xdata_addr_out,
   output reg              xdata_valid_out,
   output reg  [PTR_W-1:0] data_pointer_out,
   input  wire             bootloader_jump_config_bit_in,
   input  wire [15:0]      code_addr_in,
   output reg              boot_select_out,
   output reg              boot_memory_map_enable_out,
   output reg              pointer_select_out
);

   reg               pointer_select_q;
   reg               user_flag_q;
   reg               boot_memory_map_enable_q;
   reg               strap_s1_q;
   reg               strap_s2_q;
   reg               in_reset_q;
   wire              hit;
   wire [7:0]        reg_view;
   wire [PTR_W-1:0]  data_pointer_zero;
   wire [PTR_W-1:0]  data_pointer_one;
   wire [PTR_W-1:0]  cur_ptr;
   wire              rd_hit;
   wire              wr_hit;
   wire              inc_hit;
   wire              any_hit;
   wire              in_boot_win;
   wire              view_sel;
   wire              view_rsv1;
   wire              view_zero;
   wire              view_flag;
   wire              view_rsv4;
   wire              view_boot;
   wire              view_rsv6;
   wire              view_rsv7;

   // ****************************************
   // register decode and view
   // ****************************************
   // address compare for the aux control register
   assign hit = (sfr_addr_in == `DDPS_AUX_ADDR); // [R9]

   // qualified strobes; increment wins over a plain write
   assign inc_hit = hit & sfr_inc_in;
   assign wr_hit  = hit & sfr_wr_in & ~sfr_inc_in;
   assign rd_hit  = hit & sfr_rd_in;
   assign any_hit = hit & (sfr_rd_in | sfr_wr_in | sfr_inc_in);

   // view bits, one per field position
   assign view_sel  = pointer_select_q;           // [R2]
   assign view_rsv1 = 1'b0;                       // [R7]
   assign view_zero = 1'b0;                       // [R3]
   assign view_flag = user_flag_q;                // [R5]
   assign view_rsv4 = 1'b0;                       // [R7]
   assign view_boot = boot_memory_map_enable_q;   // [R6]
   assign view_rsv6 = 1'b0;                       // [R7]
   assign view_rsv7 = 1'b0;                       // [R7]

   // reserved bits read zero so software needs no mask
   assign reg_view = {view_rsv7, view_rsv6, view_boot, view_rsv4,
                      view_flag, view_zero, view_rsv1, view_sel};

   // boot window compare on the code fetch address
   assign in_boot_win = (code_addr_in >= `DDPS_BOOT_LO) &&
                        (code_addr_in <= `DDPS_BOOT_HI); // [R6]

   // ****************************************
   // strap synchroniser
   // ****************************************
   always @(posedge clk_in) begin
      strap_s1_q <= bootloader_jump_config_bit_in;
      strap_s2_q <= strap_s1_q;
      in_reset_q <= srst_in;
   end

   // ****************************************
   // aux control register
   // ****************************************
   // select: increment with bit 2 at zero flips only this bit
   always @(posedge clk_in) begin
      if (srst_in) begin
         pointer_select_q <= 1'b0;                   // [R8]
      end else if (inc_hit) begin
         pointer_select_q <= ~pointer_select_q;      // [R4] [R3]
      end else if (wr_hit) begin
         pointer_select_q <= sfr_wdata_in[`DDPS_SEL_BIT];  // [R2]
      end
   end

   // user flag: software only, an increment never carries into it
   always @(posedge clk_in) begin
      if (srst_in) begin
         user_flag_q <= `DDPS_FLAG_RST;
      end else if (wr_hit) begin
         user_flag_q <= sfr_wdata_in[`DDPS_FLAG_BIT]; // [R5]
      end
   end

   // boot enable: strap value is taken while reset is held and
   // on the edge after release, then software owns it
   always @(posedge clk_in) begin
      if (srst_in || in_reset_q) begin
         boot_memory_map_enable_q <= strap_s2_q;     // [R8]
      end else if (wr_hit) begin
         boot_memory_map_enable_q <= sfr_wdata_in[`DDPS_BOOT_BIT];
      end
   end

   // ****************************************
   // the two pointers
   // ****************************************
   ddps_ptr_reg #(
      .WIDTH     (PTR_W)
   ) u_ptr_zero (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .load_in   (ptr_load_in & ~pointer_select_q),  // [R10] [R1]
      .inc_in    (ptr_inc_in & ~pointer_select_q),
      .data_in   (ptr_data_in),
      .value_out (data_pointer_zero)
   );

   ddps_ptr_reg #(
      .WIDTH     (PTR_W)
   ) u_ptr_one (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .load_in   (ptr_load_in & pointer_select_q),   // [R10] [R1]
      .inc_in    (ptr_inc_in & pointer_select_q),
      .data_in   (ptr_data_in),
      .value_out (data_pointer_one)
   );

   // selected pointer feeds the external data address and the core pointer output
   assign cur_ptr = pointer_select_q ? data_pointer_one
                                     : data_pointer_zero; // [R2]

   // ****************************************
   // registered outputs
   // ****************************************
   // read data stands one cycle after a read strobe, else zero
   always @(posedge clk_in) begin
      if (srst_in) begin
         sfr_rdata_out <= 8'h00;
      end else begin
         sfr_rdata_out <= rd_hit ? reg_view : 8'h00; // [R9]
      end
   end

   // hit pulse for any strobe at the aux address
   always @(posedge clk_in) begin
      if (srst_in) begin
         sfr_hit_out <= 1'b0;
      end else begin
         sfr_hit_out <= any_hit;                      // [R9]
      end
   end

   // external data address from the selected pointer
   always @(posedge clk_in) begin
      if (srst_in) begin
         xdata_addr_out <= {PTR_W{1'b0}};
      end else begin
         xdata_addr_out <= cur_ptr;                   // [R10]
      end
   end

   // access valid follows the request by one cycle
   always @(posedge clk_in) begin
      if (srst_in) begin
         xdata_valid_out <= 1'b0;
      end else begin
         xdata_valid_out <= xdata_req_in;             // [R1]
      end
   end

   // selected pointer value for the core
   always @(posedge clk_in) begin
      if (srst_in) begin
         data_pointer_out <= {PTR_W{1'b0}};
      end else begin
         data_pointer_out <= cur_ptr;                 // [R2]
      end
   end

   // boot memory selected only inside the window with enable set
   always @(posedge clk_in) begin
      if (srst_in) begin
         boot_select_out <= 1'b0;
      end else begin
         boot_select_out <= boot_memory_map_enable_q & in_boot_win; // [R6]
      end
   end

   // registered copy of the boot enable bit
   always @(posedge clk_in) begin
      if (srst_in) begin
         boot_memory_map_enable_out <= 1'b0;
      end else begin
         boot_memory_map_enable_out <= boot_memory_map_enable_q;
      end
   end

   // registered copy of the pointer select bit
   always @(posedge clk_in) begin
      if (srst_in) begin
         pointer_select_out <= 1'b0;
      end else begin
         pointer_select_out <= pointer_select_q;
      end
   end

endmodule

// file: tb_dual_data_pointer_select.sv
// tb_dual_data_pointer_select.sv: self-checking bench for ddps_top.
// assumes the design files and ddps_sva.sv are compiled first.
`timescale 1ns/1ps
module tb_dual_data_pointer_select;
   logic clk_in = 0, srst_in = 1, sfr_wr_in = 0, sfr_inc_in = 0, sfr_rd_in = 0, hv, xv;
   logic ptr_load_in = 0, ptr_inc_in = 0, xdata_req_in = 0, bootloader_jump_config_bit_in = 1;
   logic [7:0] sfr_addr_in = 8'hA2, sfr_wdata_in = 8'h00, sfr_rdata_out, rv;
   logic [15:0] ptr_data_in = 16'h0000, code_addr_in = 16'h0000, xdata_addr_out, data_pointer_out;
   logic sfr_hit_out, xdata_valid_out, boot_select_out, boot_memory_map_enable_out, pointer_select_out;
   int num_errors = 0, total_checks = 0;
   ddps_top dut_u (.*);
   // 40 MHz core clock
   always #12.5 clk_in = ~clk_in;
   task chk(input string nm, input [15:0] e, input [15:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one strobe cycle, capture read slot, one settle cycle
   task sfr(input [7:0] a, input w, i, r, input [7:0] d);
      {sfr_addr_in, sfr_wr_in, sfr_inc_in, sfr_rd_in, sfr_wdata_in} = {a, w, i, r, d};
      @(negedge clk_in);
      rv = sfr_rdata_out;
      hv = sfr_hit_out;
      {sfr_wr_in, sfr_inc_in, sfr_rd_in} = 3'b000;
      @(negedge clk_in);
   endtask
   task ptr(input l, n, x, input [15:0] d);
      {ptr_load_in, ptr_inc_in, xdata_req_in, ptr_data_in} = {l, n, x, d};
      @(negedge clk_in);
      xv = xdata_valid_out;
      {ptr_load_in, ptr_inc_in, xdata_req_in} = 3'b000;
      @(negedge clk_in);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (2) @(negedge clk_in);
      srst_in = 0;
      repeat (2) @(negedge clk_in);
      chk("boot_en", 1, boot_memory_map_enable_out);
      sfr(8'hA2, 0, 0, 1, 0);
      chk("rd_reset", 8'h20, rv);
      $display("test reset done");
      sfr(8'hA2, 1, 0, 0, 8'h2D); // reserved bits written as zero
      sfr(8'hA2, 0, 0, 1, 0);
      chk("rd_all_ones", 8'h29, rv);
      code_addr_in = 16'hF800;
      @(negedge clk_in);
      chk("boot_lo", 1, boot_select_out);
      code_addr_in = 16'hF7FF;
      @(negedge clk_in);
      chk("boot_below", 0, boot_select_out);
      sfr(8'hA2, 1, 0, 0, 8'h08);
      code_addr_in = 16'hFFFF;
      @(negedge clk_in);
      chk("boot_off", 0, boot_select_out);
      $display("test fields done");
      sfr(8'hA2, 0, 1, 0, 0);
      chk("inc_sel", 1, pointer_select_out);
      sfr(8'hA2, 0, 0, 1, 0);
      chk("rd_inc", 8'h09, rv);
      sfr(8'hA2, 0, 1, 0, 0);
      sfr(8'hA2, 0, 0, 1, 0);
      chk("rd_inc2", 8'h08, rv);
      sfr(8'hA3, 1, 0, 0, 8'h01);
      chk("hit_other", 0, hv);
      chk("sel_other", 0, pointer_select_out);
      $display("test increment done");
      ptr(1, 0, 0, 16'h1234);
      chk("dp0", 16'h1234, data_pointer_out);
      chk("xvalid_idle", 0, xv);
      sfr(8'hA2, 0, 1, 0, 0);
      ptr(1, 0, 0, 16'hABCD);
      ptr(0, 1, 0, 0);
      chk("dp1_inc", 16'hABCE, data_pointer_out);
      sfr(8'hA2, 0, 1, 0, 0);
      chk("dp0_kept", 16'h1234, data_pointer_out);
      ptr(0, 0, 1, 0);
      chk("xaddr", 16'h1234, xdata_addr_out);
      chk("xvalid", 1, xv);
      $display("test pointers done");
      report_and_stop();
   end
endmodule
